//--- cdr_rate_search.sv
// Per-channel divide ratio enable decode and lock search sequencer
`timescale 1ns/1ns
module cdr_rate_search (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] rate_subrate,
    input wire logic cdr_hold,
    input wire logic signal_present,
    input wire logic cdr_locked,
    output logic [3:0] group0_div_en_r,
    output logic [3:0] group1_div_en_r,
    output logic search_active_r,
    output logic search_group_r,
    output logic [1:0] search_div_r,
    output logic lock_found_r
);
    // Bits 7:4 are group 0, bits 3:0 group 1; bit n of each nibble enables divide by 2**n
    logic [7:0] masks_nxt;
    always_comb begin
        case (rate_subrate)
            4'h0: masks_nxt = 8'h81;
            4'h1: masks_nxt = 8'h71;
            4'h2: masks_nxt = 8'h77;
            4'h3: masks_nxt = 8'h77;
            4'h4: masks_nxt = 8'h66;
            4'h5: masks_nxt = 8'h55;
            4'h6: masks_nxt = 8'hFF;
            4'h7: masks_nxt = 8'h11;
            4'h8: masks_nxt = 8'h11;
            4'h9: masks_nxt = 8'h11;
            4'hA: masks_nxt = 8'h22;
            4'hB: masks_nxt = 8'h66;
            4'hF: masks_nxt = 8'h81;
            default: masks_nxt = 8'h11;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            group0_div_en_r <= 4'hF;
            group1_div_en_r <= 4'hF;
        end else begin
            group0_div_en_r <= masks_nxt[7:4];
            group1_div_en_r <= masks_nxt[3:0];
        end
    end

    typedef logic [retimer_regs_pkg::DWELL_W-1:0] dwell_t;

    // Candidate index: upper bits walk divide 8 down to 1, low bit picks group
    retimer_regs_pkg::search_state_e state_r;
    logic [2:0] cand_r;
    logic [retimer_regs_pkg::DWELL_W-1:0] dwell_r;
    logic [1:0] cand_div;
    logic cand_en;

    assign cand_div = 2'h3 - cand_r[2:1];
    assign cand_en = cand_r[0] ? group1_div_en_r[cand_div] : group0_div_en_r[cand_div];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= retimer_regs_pkg::SRCH_IDLE;
            cand_r <= 3'h0;
            dwell_r <= '0;
        end else if (cdr_hold) begin
            state_r <= retimer_regs_pkg::SRCH_IDLE;
            cand_r <= 3'h0;
            dwell_r <= '0;
        end else begin
            case (state_r)
                retimer_regs_pkg::SRCH_IDLE: begin
                    cand_r <= 3'h0;
                    dwell_r <= '0;
                    if (signal_present) begin
                        state_r <= retimer_regs_pkg::SRCH_SCAN;
                    end
                end
                retimer_regs_pkg::SRCH_SCAN: begin
                    if (!signal_present) begin
                        state_r <= retimer_regs_pkg::SRCH_IDLE;
                    end else if (!cand_en) begin
                        cand_r <= cand_r + 3'h1;
                        dwell_r <= '0;
                    end else if (cdr_locked) begin
                        state_r <= retimer_regs_pkg::SRCH_LOCKED;
                    end else if (dwell_r ==
                            dwell_t'(retimer_regs_pkg::SEARCH_DWELL_CYC - 1)) begin
                        cand_r <= cand_r + 3'h1;
                        dwell_r <= '0;
                    end else begin
                        dwell_r <= dwell_r + 1'b1;
                    end
                end
                retimer_regs_pkg::SRCH_LOCKED: begin
                    if (!cdr_locked || !signal_present) begin
                        state_r <= retimer_regs_pkg::SRCH_IDLE;
                    end
                end
                default: state_r <= retimer_regs_pkg::SRCH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            search_active_r <= 1'b0;
            search_group_r <= 1'b0;
            search_div_r <= 2'h3;
            lock_found_r <= 1'b0;
        end else begin
            search_active_r <= (state_r == retimer_regs_pkg::SRCH_SCAN);
            search_group_r <= cand_r[0];
            search_div_r <= cand_div;
            lock_found_r <= (state_r == retimer_regs_pkg::SRCH_LOCKED);
        end
    end
endmodule

//--- retimer_host_model.sv
// Host side of the register port: byte writes and reads
`timescale 1ns/1ns
module retimer_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic reg_rvalid_r
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // Stale data must not look valid once released
        reg_wdata <= ~d;
    endtask
    // Whole byte every time; leftover routing bits would misroute
    task automatic set_sel(input logic [7:0] v);
        wr(8'hFF, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        n = 0;
        while (!reg_rvalid_r && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = reg_rvalid_r ? reg_rdata_r : 8'hXX;
    endtask
endmodule

//--- retimer_regs_chk.sv
// Checker for register routing, CDR hold and lock search outputs
`timescale 1ns/1ns
module retimer_regs_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic reg_rvalid_r,
    input wire logic [1:0] cdr_hold_r,
    input wire logic [3:0] adapt_mode_r,
    input wire logic [7:0] group0_div_en_r,
    input wire logic [7:0] group1_div_en_r,
    input wire logic [1:0] search_active_r,
    input wire logic [3:0] search_div_r,
    input wire logic [1:0] lock_found_r
);
    logic [7:0] sel_r;
    logic ch0_w;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // Shadow of the select byte; shared reset also clears it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= 8'h00;
        end else if (reg_wr && reg_addr == 8'hFF) begin
            sel_r <= reg_wdata;
        end else if (reg_wr && !sel_r[2] && reg_addr == 8'h04 && reg_wdata[6]) begin
            sel_r <= 8'h00;
        end
    end
    assign ch0_w = sel_r[2] && !sel_r[1] && (sel_r[3] || !sel_r[0]);

    property p_rd_answer;
        reg_rvalid_r == $past(reg_rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_id;
        reg_rd && !sel_r[2] && reg_addr == 8'h01 |=>
            reg_rdata_r == {retimer_regs_pkg::DEVICE_ID, retimer_regs_pkg::DEVICE_REVISION};
    endproperty
    a_id: assert property (p_id) else $error("identity read wrong");
    property p_sel_read;
        reg_rd && reg_addr == 8'hFF |=> reg_rdata_r == sel_r;
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select read wrong");
    property p_bad_chan;
        reg_rd && sel_r[2] && sel_r[1] && reg_addr != 8'hFF |=> reg_rdata_r == 8'h00;
    endproperty
    a_bad_chan: assert property (p_bad_chan) else $error("bad channel read");
    property p_hold;
        reg_wr && ch0_w && reg_addr == 8'h0A && (&reg_wdata[3:2]) |-> ##2 cdr_hold_r[0];
    endproperty
    a_hold: assert property (p_hold) else $error("CDR hold not set");
    property p_bcast;
        reg_wr && sel_r[3:2] == 2'b11 && !sel_r[1] && reg_addr == 8'h0A && (&reg_wdata[3:2])
            |-> ##2 cdr_hold_r == 2'b11;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast hold wrong");
    property p_adapt;
        reg_wr && ch0_w && reg_addr == 8'h31 |-> ##2 adapt_mode_r[1:0] == $past(reg_wdata[6:5], 2);
    endproperty
    a_adapt: assert property (p_adapt) else $error("adapt mode wrong");
    property p_div;
        reg_wr && ch0_w && reg_addr == 8'h2F && reg_wdata[7:4] == 4'h0
            |-> ##2 group0_div_en_r[3:0] == 4'h8 && group1_div_en_r[3:0] == 4'h1;
    endproperty
    a_div: assert property (p_div) else $error("divide enables wrong");
    property p_hold_idle;
        cdr_hold_r[0] [*3] |-> !search_active_r[0];
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("search runs in hold");
    // Candidate divide only steps downward, wrapping 1 back to 8
    property p_order;
        search_active_r[0] && $past(search_active_r[0]) && search_div_r[1:0] != $past(search_div_r[1:0])
            |-> search_div_r[1:0] == $past(search_div_r[1:0]) - 2'd1;
    endproperty
    a_order: assert property (p_order) else $error("search order wrong");

    c_bcast: cover property (reg_wr && sel_r[3:2] == 2'b11);
    c_lock: cover property ($rose(lock_found_r[0]));
    c_sel_read: cover property (reg_rd && reg_addr == 8'hFF);
endmodule

bind retimer_smbus_register_control retimer_regs_chk i_retimer_regs_chk (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .reg_rvalid_r,
    .cdr_hold_r, .adapt_mode_r, .group0_div_en_r, .group1_div_en_r, .search_active_r,
    .search_div_r, .lock_found_r
);

//--- retimer_regs_pkg.sv
// Register map, field positions, reset values and timing for the retimer register control
package retimer_regs_pkg;
    localparam int NUM_CHAN = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 256;
    localparam int STRAP_W = 4;

    // Shared register offsets
    localparam logic [7:0] SHARED_STRAP_OBSERVE = 8'h00;
    localparam logic [7:0] REVISION_AND_IDENTITY = 8'h01;
    localparam logic [7:0] SHARED_RESET_CTRL = 8'h04;
    localparam logic [7:0] INTERRUPT_CHANNEL_FLAGS = 8'h05;
    localparam logic [7:0] DIAGNOSTIC_TEST_CTRL = 8'h06;
    localparam logic [7:0] REGISTER_SET_SELECT = 8'hFF;

    // Channel register offsets
    localparam logic [7:0] CHANNEL_SOFT_RESET_CTRL = 8'h00;
    localparam logic [7:0] CDR_RESET_OVERRIDE = 8'h0A;
    localparam logic [7:0] RATE_SUBRATE_SELECT = 8'h2F;
    localparam logic [7:0] ADAPT_MODE_CTRL = 8'h31;

    // Field positions
    localparam int STRAP_LSB = 4;
    localparam int DIAG_LSB = 0;
    localparam int SHARED_SOFT_RESET_BIT = 6;
    localparam int CHAN_SOFT_RESET_BIT = 2;
    localparam int CDR_OVR_LSB = 2;
    localparam int RATE_SUB_LSB = 4;
    localparam int ADAPT_LSB = 5;
    localparam int SEL_CHAN_LSB = 0;
    localparam int SEL_ENABLE_BIT = 2;
    localparam int SEL_BCAST_BIT = 3;

    // Field values
    localparam logic [3:0] DIAG_STRAP_VIEW = 4'hA;
    localparam logic [1:0] CDR_OVR_BOTH = 2'h3;

    // Reset values
    localparam logic [7:0] SHARED_DEFAULT = 8'h00;
    localparam logic [7:0] CHAN_DEFAULT = 8'h00;
    localparam logic [7:0] RATE_SUBRATE_DEFAULT = 8'h60;

    // Identity, values arbitrary
    localparam logic [3:0] DEVICE_REVISION = 4'h1;
    localparam logic [3:0] DEVICE_ID = 4'h2;

    // Lock search dwell per candidate ratio
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEARCH_DWELL_NS = 2000;
    localparam int SEARCH_DWELL_CYC = SEARCH_DWELL_NS / CLK_PERIOD_NS;
    localparam int DWELL_W = 8;

    typedef enum logic [1:0] {
        SRCH_IDLE = 2'b00,
        SRCH_SCAN = 2'b01,
        SRCH_LOCKED = 2'b10
    } search_state_e;
endpackage

//--- retimer_smbus_register_control.sv
// Shared and per-channel register sets with channel select, resets and CDR control
//
// Functional notes
// - With diagnostic field 0xA, shared 0x00 bits 7:4 read the power-up strap value.
// - Writing one to shared 0x04 bit 6 resets all shared registers; bit self-clears.
// - Shared 0x01 is read-only and returns revision and device identifier.
// - Channel select bit 3 set with bits 1:0 at 0 or 1 makes channel writes land in both channel sets.
// - Channel reads come only from the channel in select bits 1:0.
// - Select bit 2 set routes addresses to channel set; clear routes to shared set.
// - Address 0xFF always reaches the shared channel select register.
// - Select 0x00 shared, 0x04 A, 0x05 B, 0x0C broadcast read A, 0x0D broadcast read B.
// - Writing one to channel 0x00 bit 2 resets that channel's registers; self-clears.
// - Both bits 3:2 of channel 0x0A set hold that channel's CDR in reset.
// - Once override clears, CDR resumes, locks if signal present, adapts per 0x31[6:5].
// - Channel 0x2F holds rate bits 7:6 and subrate bits 5:4, reset value 0110.
// - Rate/subrate picks a fixed set of divide ratios per group.
// - Lock search tries enabled ratios from divide by 8 toward divide by 1.
// - Default search covers both group primary rates plus their divided rates.
`timescale 1ns/1ns
module retimer_smbus_register_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    output logic reg_rvalid_r,
    input wire logic [3:0] addr_strap,
    input wire logic [1:0] signal_present,
    input wire logic [1:0] cdr_locked,
    output logic [1:0] cdr_hold_r,
    output logic [3:0] adapt_mode_r,
    output logic [7:0] group0_div_en_r,
    output logic [7:0] group1_div_en_r,
    output logic [1:0] search_active_r,
    output logic [1:0] search_group_r,
    output logic [3:0] search_div_r,
    output logic [1:0] lock_found_r
);
    localparam int NCH = retimer_regs_pkg::NUM_CHAN;

    logic [7:0] shared_mem_r [retimer_regs_pkg::REG_COUNT];
    logic [7:0] chan_mem_r [NCH][retimer_regs_pkg::REG_COUNT];

    // Strap pins are asynchronous; two stages before use
    logic [3:0] strap_meta_r;
    logic [3:0] strap_sync_r;
    logic [3:0] strap_held_r;
    logic strap_taken_r;
    logic [1:0] strap_age_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_r <= 4'h0;
            strap_sync_r <= 4'h0;
            strap_age_r <= 2'b00;
        end else begin
            strap_meta_r <= addr_strap;
            strap_sync_r <= strap_meta_r;
            strap_age_r <= {strap_age_r[0], 1'b1};
        end
    end

    // Caught once after release, like a power-up sample; soft resets keep it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strap_held_r <= 4'h0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r && strap_age_r[1]) begin // Skip the synchroniser's reset zero
            strap_held_r <= strap_sync_r;
            strap_taken_r <= 1'b1;
        end
    end

    logic [1:0] sig_meta_r;
    logic [1:0] sig_sync_r;
    logic [1:0] lock_meta_r;
    logic [1:0] lock_sync_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sig_meta_r <= 2'h0;
            sig_sync_r <= 2'h0;
            lock_meta_r <= 2'h0;
            lock_sync_r <= 2'h0;
        end else begin
            sig_meta_r <= signal_present;
            sig_sync_r <= sig_meta_r;
            lock_meta_r <= cdr_locked;
            lock_sync_r <= lock_meta_r;
        end
    end

    // Address routing
    logic [7:0] select_val;
    logic to_channel;
    logic chan_valid;
    logic chan_idx;
    logic bcast;
    logic shared_soft_reset;

    assign select_val = shared_mem_r[retimer_regs_pkg::REGISTER_SET_SELECT];
    assign to_channel = select_val[retimer_regs_pkg::SEL_ENABLE_BIT]
        && (reg_addr != retimer_regs_pkg::REGISTER_SET_SELECT);
    // Only channel codes 0 and 1 exist; others reach nothing
    assign chan_valid = (select_val[1:0] < 2'(NCH));
    assign chan_idx = select_val[retimer_regs_pkg::SEL_CHAN_LSB];
    assign bcast = select_val[retimer_regs_pkg::SEL_BCAST_BIT];
    assign shared_soft_reset = reg_wr && !to_channel
        && (reg_addr == retimer_regs_pkg::SHARED_RESET_CTRL)
        && reg_wdata[retimer_regs_pkg::SHARED_SOFT_RESET_BIT];

    // Shared set; the reset bit is never stored so it reads back clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < retimer_regs_pkg::REG_COUNT; i++) begin
                shared_mem_r[i] <= retimer_regs_pkg::SHARED_DEFAULT;
            end
        end else if (shared_soft_reset) begin
            for (int i = 0; i < retimer_regs_pkg::REG_COUNT; i++) begin
                shared_mem_r[i] <= retimer_regs_pkg::SHARED_DEFAULT;
            end
        end else if (reg_wr && !to_channel
                && reg_addr != retimer_regs_pkg::REVISION_AND_IDENTITY) begin
            shared_mem_r[reg_addr] <= reg_wdata;
        end
    end

    // Channel sets, one per generate pass
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic hit;
            logic ch_soft_reset;
            logic [7:0] ch_default [retimer_regs_pkg::REG_COUNT];

            assign hit = reg_wr && to_channel && chan_valid
                && (bcast || (chan_idx == 1'(ch)));
            assign ch_soft_reset = hit && (reg_addr == retimer_regs_pkg::CHANNEL_SOFT_RESET_CTRL)
                && reg_wdata[retimer_regs_pkg::CHAN_SOFT_RESET_BIT];

            always_comb begin
                for (int i = 0; i < retimer_regs_pkg::REG_COUNT; i++) begin
                    ch_default[i] = (8'(i) == retimer_regs_pkg::RATE_SUBRATE_SELECT)
                        ? retimer_regs_pkg::RATE_SUBRATE_DEFAULT
                        : retimer_regs_pkg::CHAN_DEFAULT;
                end
            end

            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    for (int i = 0; i < retimer_regs_pkg::REG_COUNT; i++) begin
                        chan_mem_r[ch][i] <= (8'(i) == retimer_regs_pkg::RATE_SUBRATE_SELECT)
                            ? retimer_regs_pkg::RATE_SUBRATE_DEFAULT
                            : retimer_regs_pkg::CHAN_DEFAULT;
                    end
                end else if (ch_soft_reset) begin
                    for (int i = 0; i < retimer_regs_pkg::REG_COUNT; i++) begin
                        chan_mem_r[ch][i] <= ch_default[i];
                    end
                end else if (hit) begin
                    chan_mem_r[ch][reg_addr] <= reg_wdata;
                end
            end

            // Override holds the CDR only; register contents are untouched
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    cdr_hold_r[ch] <= 1'b0;
                    adapt_mode_r[2*ch +: 2] <= 2'h0;
                end else begin
                    cdr_hold_r[ch] <= (chan_mem_r[ch][retimer_regs_pkg::CDR_RESET_OVERRIDE]
                        [retimer_regs_pkg::CDR_OVR_LSB +: 2] == retimer_regs_pkg::CDR_OVR_BOTH);
                    adapt_mode_r[2*ch +: 2] <= chan_mem_r[ch][retimer_regs_pkg::ADAPT_MODE_CTRL]
                        [retimer_regs_pkg::ADAPT_LSB +: 2];
                end
            end

            cdr_rate_search u_search (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .rate_subrate(chan_mem_r[ch][retimer_regs_pkg::RATE_SUBRATE_SELECT]
                    [retimer_regs_pkg::RATE_SUB_LSB +: 4]),
                .cdr_hold(cdr_hold_r[ch]),
                .signal_present(sig_sync_r[ch]),
                .cdr_locked(lock_sync_r[ch]),
                .group0_div_en_r(group0_div_en_r[4*ch +: 4]),
                .group1_div_en_r(group1_div_en_r[4*ch +: 4]),
                .search_active_r(search_active_r[ch]),
                .search_group_r(search_group_r[ch]),
                .search_div_r(search_div_r[2*ch +: 2]),
                .lock_found_r(lock_found_r[ch])
            );
        end
    endgenerate

    // Read path
    logic [7:0] shared_rd;
    logic [7:0] rd_nxt;

    always_comb begin
        shared_rd = shared_mem_r[reg_addr];
        if (reg_addr == retimer_regs_pkg::REVISION_AND_IDENTITY) begin
            shared_rd = {retimer_regs_pkg::DEVICE_ID,
                retimer_regs_pkg::DEVICE_REVISION};
        end else if (reg_addr == retimer_regs_pkg::SHARED_STRAP_OBSERVE
                && shared_mem_r[retimer_regs_pkg::DIAGNOSTIC_TEST_CTRL]
                [retimer_regs_pkg::DIAG_LSB +: 4] == retimer_regs_pkg::DIAG_STRAP_VIEW) begin
            shared_rd[retimer_regs_pkg::STRAP_LSB +: 4] = strap_held_r;
        end
    end

    always_comb begin
        if (!to_channel) begin
            rd_nxt = shared_rd;
        end else if (chan_valid) begin
            rd_nxt = chan_mem_r[chan_idx][reg_addr];
        end else begin
            rd_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_nxt;
            end
        end
    end
endmodule

//--- tb_top.sv
// Testbench for the retimer register control block
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [7:0] wsel, addr, wdata, rsel, exp;} row_s;
    logic clk_sys, reset_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
    logic reg_wr, reg_rd, reg_rvalid_r;
    logic [3:0] addr_strap, adapt_mode_r, search_div_r;
    logic [1:0] signal_present, cdr_locked, cdr_hold_r, search_active_r, search_group_r;
    logic [1:0] lock_found_r;
    logic [7:0] group0_div_en_r, group1_div_en_r;
    int err_total = 0;
    int n_checks = 0;
    // Per rate/subrate code, bit n enables divide by 2**n
    logic [63:0] g0_tab = 64'h8111_6211_1F56_7778;
    logic [63:0] g1_tab = 64'h1111_6211_1F56_7711;
    row_s rows [10] = '{
        '{8'h04, 8'h31, 8'h5A, 8'h04, 8'h5A}, '{8'h05, 8'h31, 8'h3C, 8'h04, 8'h5A},
        '{8'h05, 8'h31, 8'h3C, 8'h05, 8'h3C}, '{8'h0C, 8'h40, 8'h77, 8'h05, 8'h77},
        '{8'h0D, 8'h41, 8'h11, 8'h04, 8'h11}, '{8'h0C, 8'h42, 8'h22, 8'h0D, 8'h22},
        '{8'h00, 8'h31, 8'h99, 8'h04, 8'h5A}, '{8'h00, 8'h31, 8'h99, 8'h00, 8'h99},
        '{8'h02, 8'h32, 8'h66, 8'h00, 8'h66}, '{8'h06, 8'h30, 8'h55, 8'h06, 8'h00}};

    retimer_smbus_register_control i_retimer_smbus_register_control (
        .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
        .reg_rvalid_r, .addr_strap, .signal_present, .cdr_locked, .cdr_hold_r, .adapt_mode_r,
        .group0_div_en_r, .group1_div_en_r, .search_active_r, .search_group_r,
        .search_div_r, .lock_found_r
    );
    retimer_host_model i_retimer_host_model (
        .clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .reg_rvalid_r
    );

    task automatic summarize;
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_retimer_host_model.wr(a, d);
    endtask
    task automatic s(input logic [7:0] v);
        i_retimer_host_model.set_sel(v);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_retimer_host_model.rd(a, d);
        chk(d, exp);
    endtask
    // Hold and divide outputs land one edge after the write, search outputs on the third; none spare
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_hi(input int lim, input bit lock);
        int n;
        n = 0;
        while (!(lock ? lock_found_r[0] : search_active_r[0]) && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (50000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        addr_strap = 4'h9;
        signal_present = 2'b11;
        cdr_locked = 2'b00;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(group0_div_en_r, 8'hFF);
        r(8'hFF, 8'h00);
        r(8'h01, 8'h21);
        w(8'h01, 8'hFF);
        r(8'h01, 8'h21);
        for (int i = 0; i < 10; i++) begin
            s(rows[i].wsel);
            w(rows[i].addr, rows[i].wdata);
            s(rows[i].rsel);
            r(rows[i].addr, rows[i].exp);
        end
        s(8'h00);
        w(8'h06, 8'h0A);
        w(8'h00, 8'h05);
        r(8'h00, 8'h95);
        w(8'h04, 8'h40);
        r(8'h06, 8'h00);
        r(8'h00, 8'h00);
        r(8'h04, 8'h00);
        s(8'h04);
        r(8'h2F, 8'h60);
        w(8'h00, 8'h04);
        r(8'h31, 8'h00);
        r(8'h00, 8'h00);
        r(8'h2F, 8'h60);
        s(8'h05);
        r(8'h31, 8'h3C);
        s(8'h04);
        w(8'h31, 8'h60);
        w(8'h0A, 8'h08);
        settle();
        chk({6'h00, cdr_hold_r}, 8'h00);
        w(8'h0A, 8'h0C);
        settle();
        chk({6'h00, cdr_hold_r}, 8'h01);
        chk({7'h00, search_active_r[0]}, 8'h00);
        r(8'h0A, 8'h0C);
        r(8'h31, 8'h60);
        chk({6'h00, adapt_mode_r[1:0]}, 8'h03);
        w(8'h0A, 8'h00);
        wait_hi(20, 1'b0);
        chk({7'h00, search_active_r[0]}, 8'h01);
        chk({5'h00, search_group_r[0], search_div_r[1:0]}, 8'h03);
        @(posedge clk_sys);
        cdr_locked <= 2'b01;
        wait_hi(20, 1'b1);
        chk({7'h00, lock_found_r[0]}, 8'h01);
        s(8'h0C);
        w(8'h0A, 8'h0C);
        settle();
        chk({6'h00, cdr_hold_r}, 8'h03);
        w(8'h0A, 8'h00);
        s(8'h04);
        for (int i = 0; i < 16; i++) begin
            w(8'h2F, {i[3:0], 4'h0});
            settle();
            chk({group1_div_en_r[3:0], group0_div_en_r[3:0]}, {g1_tab[i*4+:4], g0_tab[i*4+:4]});
        end
        w(8'h2F, 8'h60);
        w(8'h60, 8'h26);
        r(8'h60, 8'h26);
        s(8'h05);
        r(8'hFF, 8'h05);
        summarize();
    end
endmodule
